//--- scc_pkg.sv
// shared constants and types for the serdes clock counters and realignment ends
package scc_pkg;
  localparam int PHASE_COUNT  = 8;
  localparam int PHASE_DEG    = 45;
  localparam int JOHNSON_W    = PHASE_COUNT / 2;
  localparam int WORD_W       = 16;
  localparam int CNT_W        = 4;
  localparam int MULT_MIN     = 1;
  localparam int MULT_MAX     = 16;
  localparam int PULSE_WORDS  = 2;
  localparam int GAP_WORDS    = 3;
  localparam int WCNT_W       = 2;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [WCNT_W-1:0] WCNT_PULSE_LAST = WCNT_W'(PULSE_WORDS);
  localparam logic [WCNT_W-1:0] WCNT_GAP_LAST   = WCNT_W'(GAP_WORDS - 1);

  typedef logic [CNT_W-1:0]  scc_cnt_t;
  typedef logic [WORD_W-1:0] scc_word_t;

  // quasi-static settings, synchronised as one bundle
  typedef struct packed {
    logic       enable;
    logic       pll_reset;
    logic       realign_enable;
    logic       rx_counter_sel;
    logic       align_from_pin;
    logic       ref_bypass;
    logic [2:0] phase_sel;
    scc_cnt_t   mult_minus1;
    scc_cnt_t   k_div;
    scc_cnt_t   k_phase;
    scc_cnt_t   v_div;
    scc_cnt_t   v_phase;
    scc_cnt_t   l_div;
    scc_cnt_t   l_phase;
  } scc_cfg_s;

  typedef enum logic [1:0] {
    SCC_IDLE  = 2'b00,
    SCC_PULSE = 2'b01,
    SCC_GAP   = 2'b10
  } scc_state_e;
endpackage

//--- scc_link_if.sv
// link between the realignment device end and the user pattern-detection end
`timescale 1ns/100ps
interface scc_link_if;
  import scc_pkg::*;
  logic      align_req;
  scc_word_t rx_word;
  logic      rx_word_toggle;

  modport dev (
    input  align_req,
    output rx_word,
    output rx_word_toggle
  );
  modport usr (
    output align_req,
    input  rx_word,
    input  rx_word_toggle
  );
endinterface

//--- scc_device.sv
// fast clock phases, post-scale counters, deserialiser and bit-slip logic
`timescale 1ns/100ps
module scc_device (
  input  wire logic              fast_link_clk_in,
  input  wire logic              nrst_in,
  scc_link_if.dev                link,
  input  wire logic              pll_global_enable_in,
  input  wire logic              pll_reset_in,
  input  wire logic              realign_enable_in,
  input  wire logic              rx_counter_sel_in,
  input  wire logic              align_from_pin_in,
  input  wire logic              align_pin_in,
  input  wire logic              ref_bypass_in,
  input  wire logic [2:0]        phase_sel_in,
  input  wire scc_pkg::scc_cnt_t mult_minus1_in,
  input  wire scc_pkg::scc_cnt_t k_div_in,
  input  wire scc_pkg::scc_cnt_t k_phase_in,
  input  wire scc_pkg::scc_cnt_t v_div_in,
  input  wire scc_pkg::scc_cnt_t v_phase_in,
  input  wire scc_pkg::scc_cnt_t l_div_in,
  input  wire scc_pkg::scc_cnt_t l_phase_in,
  input  wire logic              rx_reference_clock_in,
  input  wire logic              serial_data_in,
  output logic [7:0]             phase_clocks_out,
  output logic                   serial_clock_out,
  output logic                   pll_locked_out,
  output logic                   rx_parallel_load_strobe_out,
  output logic                   tx_parallel_load_strobe_out,
  output logic                   local_clock_out,
  output logic                   global_clock_net_out,
  output logic                   counter_stall_pulse_a_out,
  output logic                   counter_stall_pulse_b_out
);
  import scc_pkg::*;

  typedef struct packed {
    scc_cfg_s               cfg_meta;
    scc_cfg_s               cfg_sync;
    logic [1:0]             req_meta;
    logic [1:0]             req_sync;
    logic                   req_prev;
    logic                   ser_meta;
    logic                   ser_sync;
    logic                   ref_meta;
    logic                   ref_sync;
    logic [PHASE_COUNT-1:0] phases;
    logic                   sel_q;
    logic                   ser_clk;
    scc_cnt_t               cnt_k;
    scc_cnt_t               cnt_v;
    scc_cnt_t               cnt_l;
    scc_cnt_t               ref_cnt;
    logic                   hit_k;
    logic                   hit_v;
    logic                   hit_l;
    logic                   locked;
    logic                   pend;
    logic                   stall;
    logic                   pulse_a;
    logic                   pulse_b;
    scc_word_t              shreg;
    scc_word_t              rx_word;
    logic                   rx_tog;
    logic                   rx_strobe;
    logic                   tx_strobe;
    logic                   global_clk;
  } scc_dev_s;

  scc_dev_s s;
  scc_dev_s next_s;
  scc_cfg_s cfg_raw;

  // divider step: wraps at the programmed ratio, holds while stalled
  function automatic scc_cnt_t scc_count(input scc_cnt_t cnt, input scc_cnt_t div, input logic hold);
    scc_cnt_t r;
    r = cnt;
    if (!hold)
    begin
      r = (cnt >= div) ? CNT_ZERO : cnt + CNT_ONE;
    end
    return r;
  endfunction

  assign cfg_raw.enable         = pll_global_enable_in;
  assign cfg_raw.pll_reset      = pll_reset_in;
  assign cfg_raw.realign_enable = realign_enable_in;
  assign cfg_raw.rx_counter_sel = rx_counter_sel_in;
  assign cfg_raw.align_from_pin = align_from_pin_in;
  assign cfg_raw.ref_bypass     = ref_bypass_in;
  assign cfg_raw.phase_sel      = phase_sel_in;
  assign cfg_raw.mult_minus1    = mult_minus1_in;
  assign cfg_raw.k_div          = k_div_in;
  assign cfg_raw.k_phase        = k_phase_in;
  assign cfg_raw.v_div          = v_div_in;
  assign cfg_raw.v_phase        = v_phase_in;
  assign cfg_raw.l_div          = l_div_in;
  assign cfg_raw.l_phase        = l_phase_in;

  always_comb
  begin
    logic run;
    logic tick;
    logic req_now;
    logic rise;
    logic stall_k;
    logic stall_v;
    run     = 1'b0;
    tick    = 1'b0;
    req_now = 1'b0;
    rise    = 1'b0;
    stall_k = 1'b0;
    stall_v = 1'b0;
    next_s  = s;

    // settings and pins are asynchronous to the fast clock
    next_s.cfg_meta = cfg_raw;
    next_s.cfg_sync = s.cfg_meta;
    next_s.req_meta = {align_pin_in, link.align_req};
    next_s.req_sync = s.req_meta;
    next_s.ser_meta = serial_data_in;
    next_s.ser_sync = s.ser_meta;
    next_s.ref_meta = rx_reference_clock_in;
    next_s.ref_sync = s.ref_meta;

    run = s.cfg_sync.enable & ~s.cfg_sync.pll_reset;

    // switching the source can itself look like a rising edge
    req_now = s.cfg_sync.align_from_pin ? s.req_sync[1] : s.req_sync[0];
    next_s.req_prev = req_now;
    rise = req_now & ~s.req_prev;

    // eight-stage ring, inverted feedback from mid-way: each tap one fast cycle later;
    // from all-zero the taps start in order, so no phase ever leads its neighbour
    next_s.phases = {s.phases[PHASE_COUNT-2:0], ~s.phases[JOHNSON_W-1]};
    next_s.sel_q   = s.phases[s.cfg_sync.phase_sel];
    next_s.ser_clk = s.sel_q;
    tick = s.phases[s.cfg_sync.phase_sel] & ~s.sel_q;

    if (rise && s.cfg_sync.realign_enable)
    begin
      next_s.pend = 1'b1;
    end
    stall_k = s.stall & ~s.cfg_sync.rx_counter_sel;
    stall_v = s.stall & s.cfg_sync.rx_counter_sel;

    if (tick)
    begin
      // the stall spans exactly one bit period, tick to tick
      if (s.pend)
      begin
        next_s.stall = 1'b1;
        next_s.pend  = 1'b0;
      end
      else
      begin
        next_s.stall = 1'b0;
      end
      next_s.cnt_k   = scc_count(s.cnt_k, s.cfg_sync.k_div, stall_k);
      next_s.cnt_v   = scc_count(s.cnt_v, s.cfg_sync.v_div, stall_v);
      next_s.cnt_l   = scc_count(s.cnt_l, s.cfg_sync.l_div, 1'b0);
      next_s.ref_cnt = scc_count(s.ref_cnt, s.cfg_sync.mult_minus1, 1'b0);
      next_s.hit_k   = (next_s.cnt_k == s.cfg_sync.k_phase);
      next_s.hit_v   = (next_s.cnt_v == s.cfg_sync.v_phase);
      next_s.hit_l   = (next_s.cnt_l == s.cfg_sync.l_phase);
      if (s.ref_cnt >= s.cfg_sync.mult_minus1)
      begin
        next_s.locked = 1'b1;
      end
      if (!s.cfg_sync.realign_enable)
      begin
        next_s.rx_strobe = next_s.hit_k;
        next_s.tx_strobe = next_s.hit_k;
      end
      else
      begin
        next_s.rx_strobe = s.cfg_sync.rx_counter_sel ? next_s.hit_v : next_s.hit_k;
        next_s.tx_strobe = (next_s.stall && !s.cfg_sync.rx_counter_sel) ? next_s.hit_v
                                                                        : next_s.hit_k;
      end
      // serial bits shift once per tick of the selected tap, not on every fast cycle
      next_s.shreg = {s.shreg[WORD_W-2:0], s.ser_sync};
      if (next_s.rx_strobe && !s.rx_strobe)
      begin
        next_s.rx_word = {s.shreg[WORD_W-2:0], s.ser_sync};
        next_s.rx_tog  = ~s.rx_tog;
      end
    end
    next_s.pulse_a    = next_s.stall & ~s.cfg_sync.rx_counter_sel;
    next_s.pulse_b    = next_s.stall & s.cfg_sync.rx_counter_sel;
    // bypass follows the reference only at fast-clock resolution
    next_s.global_clk = s.cfg_sync.ref_bypass ? s.ref_sync : s.hit_l;

    if (!run)
    begin
      // counters restart together so they resynchronise on release
      next_s.phases     = '0;
      next_s.sel_q      = 1'b0;
      next_s.ser_clk    = 1'b0;
      next_s.cnt_k      = CNT_ZERO;
      next_s.cnt_v      = CNT_ZERO;
      next_s.cnt_l      = CNT_ZERO;
      next_s.ref_cnt    = CNT_ZERO;
      next_s.hit_k      = 1'b0;
      next_s.hit_v      = 1'b0;
      next_s.hit_l      = 1'b0;
      next_s.locked     = 1'b0;
      next_s.pend       = 1'b0;
      next_s.stall      = 1'b0;
      next_s.pulse_a    = 1'b0;
      next_s.pulse_b    = 1'b0;
      next_s.rx_strobe  = 1'b0;
      next_s.tx_strobe  = 1'b0;
      next_s.global_clk = 1'b0;
    end
  end

  always_ff @(posedge fast_link_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign phase_clocks_out            = s.phases;
  assign serial_clock_out            = s.ser_clk;
  assign pll_locked_out              = s.locked;
  assign rx_parallel_load_strobe_out = s.rx_strobe;
  assign tx_parallel_load_strobe_out = s.tx_strobe;
  assign local_clock_out             = s.hit_k;
  assign global_clock_net_out        = s.global_clk;
  assign counter_stall_pulse_a_out   = s.pulse_a;
  assign counter_stall_pulse_b_out   = s.pulse_b;
  assign link.rx_word                = s.rx_word;
  assign link.rx_word_toggle         = s.rx_tog;
endmodule // scc_device

//--- scc_user.sv
// user-side pattern detection that issues bit-slip requests
`timescale 1ns/100ps
module scc_user (
  input  wire logic               clk_in,
  input  wire logic               nrst_in,
  scc_link_if.usr                 link,
  input  wire logic               align_enable_in,
  input  wire scc_pkg::scc_word_t pattern_in,
  input  wire scc_pkg::scc_word_t pattern_mask_in,
  output scc_pkg::scc_word_t      word_out,
  output logic                    word_valid_out,
  output logic                    aligned_out,
  output logic                    slip_busy_out
);
  import scc_pkg::*;

  typedef struct packed {
    logic              tog_meta;
    logic              tog_sync;
    logic              tog_prev;
    scc_word_t         word;
    logic              word_valid;
    logic              aligned;
    scc_state_e        state;
    logic [WCNT_W-1:0] wcnt;
    logic              req;
  } scc_usr_s;

  scc_usr_s s;
  scc_usr_s next_s;

  always_comb
  begin
    logic word_evt;
    logic match;
    word_evt = 1'b0;
    match    = 1'b0;
    next_s   = s;
    next_s.tog_meta   = link.rx_word_toggle;
    next_s.tog_sync   = s.tog_meta;
    next_s.tog_prev   = s.tog_sync;
    next_s.word_valid = 1'b0;
    // each arriving word marks one slow-clock period
    word_evt = s.tog_sync ^ s.tog_prev;
    if (word_evt)
    begin
      // word changes with the toggle and then holds for a full word period, so it is settled when the synchronised toggle lands
      next_s.word       = link.rx_word;
      next_s.word_valid = 1'b1;
    end
    match = ((s.word ^ pattern_in) & pattern_mask_in) == '0;
    case (s.state)
      SCC_IDLE:
      begin
        if (s.word_valid)
        begin
          next_s.aligned = match;
          if (!match && align_enable_in)
          begin
            next_s.state = SCC_PULSE;
            next_s.wcnt  = '0;
          end
        end
      end
      SCC_PULSE:
      begin
        if (word_evt)
        begin
          // entry lands two cycles after a word arrives, so one extra word keeps two full periods
          if (s.wcnt == WCNT_PULSE_LAST)
          begin
            next_s.state = SCC_GAP;
            next_s.wcnt  = '0;
          end
          else
          begin
            next_s.wcnt = s.wcnt + 1'b1;
          end
        end
      end
      SCC_GAP:
      begin
        if (word_evt)
        begin
          if (s.wcnt == WCNT_GAP_LAST)
          begin
            next_s.state = SCC_IDLE;
            next_s.wcnt  = '0;
          end
          else
          begin
            next_s.wcnt = s.wcnt + 1'b1;
          end
        end
      end
      default:
      begin
        next_s.state = SCC_IDLE;
        next_s.wcnt  = '0;
      end
    endcase
    next_s.req = (s.state == SCC_PULSE);
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign link.align_req = s.req;
  assign word_out       = s.word;
  assign word_valid_out = s.word_valid;
  assign aligned_out    = s.aligned;
  assign slip_busy_out  = (s.state != SCC_IDLE);
endmodule // scc_user

//--- scc_asserts.sv
// concurrent checks on the link and on the device strobe and stall outputs
`timescale 1ns/100ps
module scc_asserts (
  input wire logic              clk_in,
  input wire logic              nrst_in,
  input wire logic              fast_link_clk_in,
  input wire logic              align_req,
  input wire scc_pkg::scc_word_t rx_word,
  input wire logic              rx_word_toggle,
  input wire logic              pll_global_enable_in,
  input wire logic              pll_reset_in,
  input wire logic              align_from_pin_in,
  input wire logic              align_pin_in,
  input wire logic [7:0]        phase_clocks_out,
  input wire logic              pll_locked_out,
  input wire logic              rx_parallel_load_strobe_out,
  input wire logic              tx_parallel_load_strobe_out,
  input wire logic              counter_stall_pulse_a_out,
  input wire logic              counter_stall_pulse_b_out
);
  import scc_pkg::*;
  typedef struct packed {
    logic [2:0] tog;
    logic       req;
    logic [1:0] cnt;
  } scc_chk_s;
  scc_chk_s st;
  scc_chk_s next_st;
  logic     halted;
  // words seen per request level; saturates so long gaps stay legal
  always_comb
  begin
    next_st = st;
    next_st.tog = {st.tog[1:0], rx_word_toggle};
    next_st.req = align_req;
    if (align_req != st.req)
      next_st.cnt = 2'h0;
    else if ((st.tog[2] ^ st.tog[1]) && (st.cnt != 2'h3))
      next_st.cnt = st.cnt + 2'h1;
  end
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      st <= {3'h0, 1'h0, 2'h3};
    else
      st <= next_st;
  end
  assign halted = !nrst_in || !pll_global_enable_in || pll_reset_in;

  req_hold_a : assert property (@(posedge clk_in) disable iff (!nrst_in)
    $fell(align_req) |-> st.cnt >= 2'h2) else $error("slip request high too briefly");
  req_gap_a : assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(align_req) |-> st.cnt == 2'h3) else $error("slip request low too briefly");
  stall_a_width_a : assert property (@(posedge fast_link_clk_in) disable iff (halted)
    $rose(counter_stall_pulse_a_out) |-> counter_stall_pulse_a_out [*8] ##1 !counter_stall_pulse_a_out [*8])
    else $error("stall a pulse length wrong");
  stall_b_width_a : assert property (@(posedge fast_link_clk_in) disable iff (halted)
    $rose(counter_stall_pulse_b_out) |-> counter_stall_pulse_b_out [*8] ##1 !counter_stall_pulse_b_out [*8])
    else $error("stall b pulse length wrong");
  stall_cause_a : assert property (@(posedge fast_link_clk_in) disable iff (halted)
    $rose(counter_stall_pulse_a_out) || $rose(counter_stall_pulse_b_out)
    |-> (align_from_pin_in ? align_pin_in : align_req)) else $error("stall without request");
  phase_ring_a : assert property (@(posedge fast_link_clk_in) disable iff (halted)
    phase_clocks_out[7:1] == $past(phase_clocks_out[6:0])) else $error("phase lag wrong");
  grounded_a : assert property (@(posedge fast_link_clk_in) disable iff (!nrst_in)
    (!pll_global_enable_in) [*6] |-> phase_clocks_out == 8'h00 && !pll_locked_out
    && !rx_parallel_load_strobe_out && !tx_parallel_load_strobe_out) else $error("outputs live while off");
  pll_clear_a : assert property (@(posedge fast_link_clk_in) disable iff (!nrst_in)
    pll_reset_in [*6] |-> phase_clocks_out == 8'h00 && !pll_locked_out) else $error("outputs live in reset");
  word_pair_a : assert property (@(posedge fast_link_clk_in) disable iff (halted)
    $changed(rx_word) |-> $changed(rx_word_toggle)) else $error("word changed without toggle");
  tx_width_a : assert property (@(posedge fast_link_clk_in) disable iff (halted)
    $rose(tx_parallel_load_strobe_out) |-> tx_parallel_load_strobe_out [*8]) else $error("tx strobe cut");
endmodule // scc_asserts

//--- testbench.sv
// testbench joining the realignment device and user ends over their link
`timescale 1ns/100ps
module testbench;
  import scc_pkg::*;
  localparam logic [7:0] TX_PAT = 8'h1D;
  logic       clk_in = 1'h0, fast_link_clk_in = 1'h0, nrst_in = 1'h0;
  logic       pll_global_enable_in = 1'h1, pll_reset_in = 1'h0, realign_enable_in = 1'h1;
  logic       rx_counter_sel_in = 1'h0, align_from_pin_in = 1'h0, align_pin_in = 1'h0;
  logic       ref_bypass_in = 1'h0, rx_reference_clock_in = 1'h0, serial_data_in = 1'h0;
  logic       align_enable_in = 1'h1;
  logic [2:0] phase_sel_in = 3'h2, bidx = 3'h7, bcnt = 3'h0;
  scc_cnt_t   mult_minus1_in = 4'h3, k_div_in = 4'h7, k_phase_in = 4'h0, v_div_in = 4'h7;
  scc_cnt_t   v_phase_in = 4'h0, l_div_in = 4'h7, l_phase_in = 4'h2;
  scc_word_t  pattern_in = 16'h001D, pattern_mask_in = 16'h00FF, word_out;
  logic [7:0] phase_clocks_out;
  logic       pll_locked_out, rx_parallel_load_strobe_out, tx_parallel_load_strobe_out, aligned_out;
  logic       global_clock_net_out, counter_stall_pulse_a_out, counter_stall_pulse_b_out;
  logic       serial_clock_out, local_clock_out, word_valid_out, slip_busy_out;
  logic [1:0] sc_hist = 2'h0;
  logic [15:0] quiet;
  int         n_fail = 0, total_checks = 0, n_st = 0, n_b = 0, mark = 0, hc = 0;
  int         lc = 0, n_wv = 0, wv_mark = 0;
  scc_link_if link ();
  scc_device i_scc_device (.fast_link_clk_in, .nrst_in, .link(link), .pll_global_enable_in, .pll_reset_in,
    .realign_enable_in, .rx_counter_sel_in, .align_from_pin_in, .align_pin_in, .ref_bypass_in, .phase_sel_in,
    .mult_minus1_in, .k_div_in, .k_phase_in, .v_div_in, .v_phase_in, .l_div_in, .l_phase_in,
    .rx_reference_clock_in, .serial_data_in, .phase_clocks_out, .serial_clock_out, .pll_locked_out,
    .rx_parallel_load_strobe_out, .tx_parallel_load_strobe_out, .local_clock_out, .global_clock_net_out,
    .counter_stall_pulse_a_out, .counter_stall_pulse_b_out);
  scc_user i_scc_user (.clk_in, .nrst_in, .link(link), .align_enable_in, .pattern_in, .pattern_mask_in,
    .word_out, .word_valid_out, .aligned_out, .slip_busy_out);
  scc_asserts i_scc_asserts (.clk_in, .nrst_in, .fast_link_clk_in, .align_req(link.align_req),
    .rx_word(link.rx_word), .rx_word_toggle(link.rx_word_toggle), .pll_global_enable_in, .pll_reset_in,
    .align_from_pin_in, .align_pin_in, .phase_clocks_out, .pll_locked_out, .rx_parallel_load_strobe_out,
    .tx_parallel_load_strobe_out, .counter_stall_pulse_a_out, .counter_stall_pulse_b_out);
  assign quiet = {pll_locked_out, rx_parallel_load_strobe_out, tx_parallel_load_strobe_out, global_clock_net_out,
                  local_clock_out, serial_clock_out, counter_stall_pulse_a_out, counter_stall_pulse_b_out,
                  phase_clocks_out};
  always #5 clk_in = ~clk_in;
  always #40 fast_link_clk_in = ~fast_link_clk_in;
  // far transmitter: one bit per eight fast cycles, msb first
  always @(posedge fast_link_clk_in)
  begin
    #1;
    if (bcnt == 3'h0)
    begin
      serial_data_in = TX_PAT[bidx];
      bidx = bidx - 3'h1;
    end
    bcnt = bcnt + 3'h1;
  end
  always @(posedge counter_stall_pulse_a_out or posedge counter_stall_pulse_b_out) n_st++;
  always @(posedge counter_stall_pulse_b_out) n_b++;
  always @(posedge word_valid_out) n_wv++;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // bounded wait for lock (0) or alignment (1)
  task automatic wait_for(input int sel, input int n);
    for (int i = 0; i < n; i++)
      if (((sel != 0) ? aligned_out : pll_locked_out) !== 1'h1)
        cyc(1);
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    cyc(16);
    nrst_in = 1'h1;
    wait_for(0, 3000);
    chk(16'(pll_locked_out), 16'h1);
    wait_for(1, 40000);
    chk(word_out & pattern_mask_in, 16'h001D);
    chk(16'(n_b), 16'h0);
    mark = n_st;
    rx_counter_sel_in = 1'h1;
    pattern_in = {8'h00, TX_PAT[4:0], TX_PAT[7:5]};
    cyc(1200);
    wait_for(1, 40000);
    chk(word_out & pattern_mask_in, pattern_in);
    chk(16'(n_st - n_b), 16'(mark));
    // upper byte never matches, so the user keeps asking
    mark = n_st;
    realign_enable_in = 1'h0;
    pattern_mask_in = 16'hFFFF;
    wv_mark = n_wv;
    cyc(8000);
    chk(16'(n_st), 16'(mark));
    chk(16'((n_wv - wv_mark) inside {[15:16]}), 16'h1);
    chk(16'(aligned_out), 16'h0);
    align_enable_in = 1'h0;
    cyc(3000);
    realign_enable_in = 1'h1;
    align_from_pin_in = 1'h1;
    cyc(100);
    align_pin_in = 1'h1;
    cyc(1100);
    align_pin_in = 1'h0;
    cyc(600);
    chk(16'(n_st - mark), 16'h1);
    chk(16'(slip_busy_out), 16'h0);
    align_from_pin_in = 1'h0;
    l_div_in = 4'h1;
    l_phase_in = 4'h0;
    cyc(400);
    for (int i = 0; i < 64; i++)
    begin
      @(negedge fast_link_clk_in);
      if (i >= 2)
        chk(16'(serial_clock_out), 16'(sc_hist[1]));
      sc_hist = {sc_hist[0], phase_clocks_out[phase_sel_in]};
      hc += int'(global_clock_net_out);
      lc += int'(local_clock_out);
    end
    chk(16'(hc), 16'h20);
    chk(16'(lc), 16'h8);
    cyc(1);
    ref_bypass_in = 1'h1;
    rx_reference_clock_in = 1'h1;
    cyc(60);
    chk(16'(global_clock_net_out), 16'h1);
    rx_reference_clock_in = 1'h0;
    cyc(60);
    chk(16'(global_clock_net_out), 16'h0);
    pll_global_enable_in = 1'h0;
    phase_sel_in = 3'h5;
    cyc(80);
    chk(quiet, 16'h0);
    pll_global_enable_in = 1'h1;
    wait_for(0, 3000);
    chk(16'(pll_locked_out), 16'h1);
    pll_reset_in = 1'h1;
    mult_minus1_in = 4'hF;
    cyc(80);
    chk(quiet, 16'h0);
    pll_reset_in = 1'h0;
    wait_for(0, 3000);
    chk(16'(pll_locked_out), 16'h1);
    print_verdict;
  end
  initial
  begin
    #950000;
    n_fail++;
    print_verdict;
  end
endmodule // testbench
